/* inc/sws_cfg.svh */
`ifndef SWS_CFG_SVH
`define SWS_CFG_SVH

// Clock and documented times
`define SWS_CLK_PERIOD_NS 100
`define SWS_WDOG_TIMEOUT_MS 1600
`define SWS_RESET_HOLD_MS 200
`define SWS_WDOG_TIMEOUT_CYC ((`SWS_WDOG_TIMEOUT_MS * 1000000) / `SWS_CLK_PERIOD_NS)
`define SWS_RESET_HOLD_CYC ((`SWS_RESET_HOLD_MS * 1000000) / `SWS_CLK_PERIOD_NS)

// Register byte offsets
`define SWS_OFF_CTRL 8'h00
`define SWS_OFF_STATUS 8'h04
`define SWS_OFF_MASK 8'h08
`define SWS_OFF_STATE 8'h0C

// Control fields
`define SWS_CTRL_WDOG_EN 0
`define SWS_CTRL_RESET 32'h0000_0001

// Event bits, shared by status and mask
`define SWS_EVT_WDOG 0
`define SWS_EVT_SUPPLY 1
`define SWS_EVT_BACKUP 2
`define SWS_EVT_WARN 3
`define SWS_EVT_W 4
`define SWS_MASK_RESET 4'h0

// Live state fields
`define SWS_ST_RESET_N 0
`define SWS_ST_WARN_N 1
`define SWS_ST_SUPPLY_LOW 2
`define SWS_ST_BACKUP 3
`define SWS_ST_KICK_FLOAT 4
`define SWS_ST_WDOG_ACTIVE 5

// Bus answers
`define SWS_RESP_OKAY 2'h0
`define SWS_RESP_DECERR 2'h3

`endif

/* inc/sws_pkg.sv */
package sws_pkg;
  // Reset generator states
  typedef enum logic [1:0] {
    rst_held,
    rst_pulse,
    rst_run
  } sws_rst_e;

  typedef logic [31:0] sws_word_t;
endpackage

/* logic/sws_sync2.sv */
`timescale 1ns/1ps
module sws_sync2 #(
  parameter int unsigned W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  if (W < 1) begin : g_chk
    $error("sws_sync2 needs W of at least 1");
  end

  // Two stages; only the second stage is read by anyone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

/* logic/sws_supervisor.sv */
`timescale 1ns/1ps
`include "sws_cfg.svh"
// What this block does
// - A missed kick within the timeout window produces a reset pulse.
// - A floating kick input disables the watchdog.
// - Battery backup mode disables the watchdog; no timeout resets.
// - Main supply below threshold asserts reset low, held through backup.
// - Active-high reset output is driven high in battery backup.
// - Backup mode disables the comparator and holds the warning low.
// - Warning output low while sensed supply is below the reference.
// - No reset while main supply is good, the backup input is low and the watchdog does not time out.
// - Reset stays low 200 ms after the main supply returns.
// - Each kick transition restarts the timeout from zero.
// - Timeout gives a 200 ms reset; static kick repeats pulses each period.
module sws_supervisor #(
  parameter int unsigned WDOG_TIMEOUT_CYC = `SWS_WDOG_TIMEOUT_CYC,
  parameter int unsigned RESET_HOLD_CYC = `SWS_RESET_HOLD_CYC,
  parameter int unsigned ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic main_supply_low,
  input wire logic backup_mode_in,
  input wire logic watchdog_kick_in_hi,
  input wire logic watchdog_kick_in_lo,
  input wire logic watchdog_kick_in_float,
  input wire logic supply_sense_in_low,
  output logic reset_out_n,
  output logic reset_out_hi,
  output logic supply_warn_n,
  output logic irq,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  localparam int unsigned CNT_W = 32;
  // Full reset word of the control register; only the enable bit is stored
  localparam logic [31:0] CTRL_RST = `SWS_CTRL_RESET;

  if (WDOG_TIMEOUT_CYC < 2 || RESET_HOLD_CYC < 2 || ADDR_W < 4) begin : g_chk
    $error("sws_supervisor parameters out of range");
  end

  // Pin inputs, all from the analog side
  logic supply_low_s;
  logic backup_s;
  logic kick_hi_s;
  logic kick_lo_s;
  logic kick_float_s;
  logic sense_low_s;

  sws_sync2 #(.W(6)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({main_supply_low, backup_mode_in, watchdog_kick_in_hi, watchdog_kick_in_lo,
        watchdog_kick_in_float, supply_sense_in_low}),
    .q({supply_low_s, backup_s, kick_hi_s, kick_lo_s, kick_float_s, sense_low_s})
  );

  // Register state
  logic ctrl_wdog_en_r;
  logic [`SWS_EVT_W-1:0] status_r;
  logic [`SWS_EVT_W-1:0] mask_r;
  logic irq_r;

  // Kick decoding
  logic kick_float_eff;
  logic kick_def;
  logic kick_level_r;
  logic kick_valid_r;
  logic kick_edge;

  // Watchdog and reset generator
  sws_pkg::sws_rst_e rst_r;
  sws_pkg::sws_rst_e rst_nxt;
  logic [CNT_W-1:0] wd_cnt_r;
  logic [CNT_W-1:0] hold_cnt_r;
  logic wdog_active;
  logic wd_timeout;
  logic hold_done;
  logic power_bad;
  logic reset_n_r;
  logic reset_hi_r;
  logic warn_n_r;
  logic warn_nxt;
  logic backup_d_r;
  logic [`SWS_EVT_W-1:0] evt_set;

  // Bus state
  logic aw_held_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic w_held_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  sws_pkg::sws_word_t rdata_r;
  logic wr_do;
  logic rd_do;
  logic [ADDR_W-1:0] wr_addr;
  logic [ADDR_W-1:0] rd_addr;
  logic [`SWS_EVT_W-1:0] status_clr;

  // Three-level kick decode
  // Both or neither of high/low counts as floating too, so a bad decode never arms
  assign kick_float_eff = kick_float_s || (kick_hi_s == kick_lo_s);
  assign kick_def = !kick_float_eff;

  // Last definite kick level; forgotten while floating
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      kick_level_r <= 1'b0;
      kick_valid_r <= 1'b0;
    end else if (kick_def) begin
      kick_level_r <= kick_hi_s;
      kick_valid_r <= 1'b1;
    end else begin
      kick_valid_r <= 1'b0;
    end
  end

  // Either direction counts as a kick
  assign kick_edge = kick_def && kick_valid_r && (kick_hi_s != kick_level_r);

  // Backup mode from its own pin
  assign power_bad = supply_low_s || backup_s;

  // Floating kick, software disable, backup or reset stop the timer
  assign wdog_active = ctrl_wdog_en_r && kick_def && !backup_s && (rst_r == sws_pkg::rst_run);
  // Timeout when the count reaches the period without a kick
  assign wd_timeout = wdog_active && !kick_edge && (wd_cnt_r == CNT_W'(WDOG_TIMEOUT_CYC - 1));

  // Watchdog counter, cleared whenever the timer is not live
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wd_cnt_r <= '0;
    end else if (!wdog_active || kick_edge || wd_timeout) begin
      wd_cnt_r <= '0;
    end else begin
      wd_cnt_r <= wd_cnt_r + 1'b1;
    end
  end

  assign hold_done = (hold_cnt_r == CNT_W'(RESET_HOLD_CYC - 1));

  // Reset generator next state
  always_comb begin
    rst_nxt = rst_r;
    unique case (rst_r)
      // Held low while supply is bad or in backup
      sws_pkg::rst_held: begin
        if (!power_bad) begin
          rst_nxt = sws_pkg::rst_pulse;
        end
      end
      sws_pkg::rst_pulse: begin
        if (power_bad) begin
          rst_nxt = sws_pkg::rst_held;
        end else if (hold_done) begin
          rst_nxt = sws_pkg::rst_run;
        end
      end
      // Only main supply, backup mode or watchdog can leave run
      sws_pkg::rst_run: begin
        if (power_bad) begin
          rst_nxt = sws_pkg::rst_held;
        end else if (wd_timeout) begin
          rst_nxt = sws_pkg::rst_pulse;
        end
      end
    endcase
  end

  // Reset generator state and hold counter
  // Watchdog pulse reuses the same timed hold
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_r <= sws_pkg::rst_held;
      hold_cnt_r <= '0;
    end else begin
      rst_r <= rst_nxt;
      if (rst_r == sws_pkg::rst_pulse && rst_nxt == sws_pkg::rst_pulse) begin
        hold_cnt_r <= hold_cnt_r + 1'b1;
      end else begin
        hold_cnt_r <= '0;
      end
    end
  end

  // Comparator ignored and warning forced low in backup
  // Warning follows the sensed supply otherwise
  assign warn_nxt = !(backup_s || sense_low_s);

  // Reset and warning outputs, registered from next state to avoid glitches
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reset_n_r <= 1'b0;
      reset_hi_r <= 1'b1;
      warn_n_r <= 1'b0;
      backup_d_r <= 1'b0;
    end else begin
      // Low for the whole of held and pulse
      reset_n_r <= (rst_nxt == sws_pkg::rst_run);
      reset_hi_r <= (rst_nxt != sws_pkg::rst_run);
      warn_n_r <= warn_nxt;
      backup_d_r <= backup_s;
    end
  end

  assign reset_out_n = reset_n_r;
  assign reset_out_hi = reset_hi_r;
  assign supply_warn_n = warn_n_r;

  // Event sources for the sticky status
  always_comb begin
    evt_set = '0;
    evt_set[`SWS_EVT_WDOG] = wd_timeout;
    evt_set[`SWS_EVT_SUPPLY] = (rst_r != sws_pkg::rst_held) && (rst_nxt == sws_pkg::rst_held);
    evt_set[`SWS_EVT_BACKUP] = backup_s && !backup_d_r;
    evt_set[`SWS_EVT_WARN] = warn_n_r && !warn_nxt;
  end

  // Write channel capture; address and data taken in either order
  assign awready = !aw_held_r && !bvalid_r;
  assign wready = !w_held_r && !bvalid_r;
  assign wr_do = aw_held_r && w_held_r && !bvalid_r;
  assign wr_addr = {awaddr_r[ADDR_W-1:2], 2'b00};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awaddr_r <= '0;
    end else if (awvalid && awready) begin
      aw_held_r <= 1'b1;
      awaddr_r <= awaddr;
    end else if (wr_do) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (wvalid && wready) begin
      w_held_r <= 1'b1;
      wdata_r <= wdata;
      wstrb_r <= wstrb;
    end else if (wr_do) begin
      w_held_r <= 1'b0;
    end
  end

  // Write response; status and state are read only, unmapped gets DECERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= `SWS_RESP_OKAY;
    end else if (wr_do) begin
      bvalid_r <= 1'b1;
      if (wr_addr == ADDR_W'(`SWS_OFF_CTRL) || wr_addr == ADDR_W'(`SWS_OFF_STATUS) ||
          wr_addr == ADDR_W'(`SWS_OFF_MASK) || wr_addr == ADDR_W'(`SWS_OFF_STATE)) begin
        bresp_r <= `SWS_RESP_OKAY;
      end else begin
        bresp_r <= `SWS_RESP_DECERR;
      end
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign bvalid = bvalid_r;
  assign bresp = bresp_r;

  // Software-writable control and mask
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_wdog_en_r <= CTRL_RST[`SWS_CTRL_WDOG_EN];
      mask_r <= `SWS_MASK_RESET;
    end else if (wr_do && wstrb_r[0]) begin
      if (wr_addr == ADDR_W'(`SWS_OFF_CTRL)) begin
        ctrl_wdog_en_r <= wdata_r[`SWS_CTRL_WDOG_EN];
      end
      if (wr_addr == ADDR_W'(`SWS_OFF_MASK)) begin
        mask_r <= wdata_r[`SWS_EVT_W-1:0];
      end
    end
  end

  // Read channel; one read in flight, answered one cycle after the address
  assign arready = !rvalid_r;
  assign rd_do = arvalid && arready;
  assign rd_addr = {araddr[ADDR_W-1:2], 2'b00};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= `SWS_RESP_OKAY;
    end else if (rd_do) begin
      rvalid_r <= 1'b1;
      rresp_r <= `SWS_RESP_OKAY;
      rdata_r <= '0;
      unique case (rd_addr)
        ADDR_W'(`SWS_OFF_CTRL): rdata_r[`SWS_CTRL_WDOG_EN] <= ctrl_wdog_en_r;
        ADDR_W'(`SWS_OFF_STATUS): rdata_r[`SWS_EVT_W-1:0] <= status_r;
        ADDR_W'(`SWS_OFF_MASK): rdata_r[`SWS_EVT_W-1:0] <= mask_r;
        ADDR_W'(`SWS_OFF_STATE): begin
          rdata_r[`SWS_ST_RESET_N] <= reset_n_r;
          rdata_r[`SWS_ST_WARN_N] <= warn_n_r;
          rdata_r[`SWS_ST_SUPPLY_LOW] <= supply_low_s;
          rdata_r[`SWS_ST_BACKUP] <= backup_s;
          rdata_r[`SWS_ST_KICK_FLOAT] <= kick_float_eff;
          rdata_r[`SWS_ST_WDOG_ACTIVE] <= wdog_active;
        end
        default: rresp_r <= `SWS_RESP_DECERR;
      endcase
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;

  // A status read clears what it returned; a new event in that cycle survives
  assign status_clr = (rd_do && rd_addr == ADDR_W'(`SWS_OFF_STATUS)) ? status_r : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= '0;
      irq_r <= 1'b0;
    end else begin
      status_r <= (status_r & ~status_clr) | evt_set;
      irq_r <= |(((status_r & ~status_clr) | evt_set) & mask_r);
    end
  end

  assign irq = irq_r;

  // Helper: length of the current low phase of reset
  logic [CNT_W-1:0] low_run_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_run_r <= '0;
    end else if (reset_n_r) begin
      low_run_r <= '0;
    end else if (low_run_r != '1) begin
      low_run_r <= low_run_r + 1'b1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_supply_low_reset: assert property (supply_low_s |=> !reset_out_n)
    else $error("reset not low with supply low");
  a_backup_reset_hi: assert property (backup_s |=> reset_out_hi && !reset_out_n)
    else $error("active-high reset not high in backup");
  a_backup_warn_low: assert property (backup_s |=> !supply_warn_n)
    else $error("warning not low in backup");
  a_sense_warn_follow: assert property (!backup_s |=> supply_warn_n == !$past(sense_low_s))
    else $error("warning does not follow sensed supply");
  a_backup_no_timeout: assert property (backup_s |-> !wd_timeout)
    else $error("watchdog timeout in backup");
  a_float_disables: assert property (kick_float_eff |-> !wdog_active && !wd_timeout)
    else $error("watchdog live with floating kick");
  a_kick_restarts: assert property (kick_edge && wdog_active |=> wd_cnt_r == '0)
    else $error("kick did not restart the timer");
  a_timeout_pulse: assert property (wd_timeout |=> !reset_out_n ##1 !reset_out_n)
    else $error("timeout gave no reset");
  a_hold_length: assert property ($rose(reset_out_n) |-> low_run_r >= RESET_HOLD_CYC)
    else $error("reset released too early");
  a_pulse_length: assert property (rst_r == sws_pkg::rst_run && wd_timeout && !power_bad
    ##1 !power_bad [*2] |-> hold_cnt_r == 1)
    else $error("watchdog pulse hold not counting");
  a_good_no_reset: assert property (rst_r == sws_pkg::rst_run && !power_bad && !wd_timeout
    |=> reset_out_n)
    else $error("spurious reset with good supply");

  c_timeout: cover property (wd_timeout);
  c_release: cover property ($rose(reset_out_n));
  c_backup_entry: cover property ($rose(backup_s));
  c_kick: cover property (kick_edge && wdog_active);
endmodule

/* verif/sws_host_model.sv */
`timescale 1ns/1ps
module sws_host_model #(
  parameter int unsigned KICK_GAP = 20
) (
  input wire logic aclk,
  input wire logic [1:0] kick_mode,
  output logic kick_hi,
  output logic kick_lo,
  output logic kick_float
);
  int unsigned cnt_r = 0;
  logic level_r = 1'b0;
  // timely host kick
  // Gap kept well under the timeout so a slow host still passes
  always_ff @(posedge aclk) begin
    if (kick_mode == 2'h2 && cnt_r >= KICK_GAP - 1) begin
      cnt_r <= 0;
      level_r <= ~level_r;
    end else begin
      cnt_r <= cnt_r + 1;
    end
  end
  assign kick_float = (kick_mode == 2'h0);
  assign kick_hi = !kick_float && level_r;
  assign kick_lo = !kick_float && !level_r;
endmodule

/* verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  localparam int WD = 50;
  localparam int HD = 20;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic main_supply_low = 1'b0;
  logic backup_mode_in = 1'b0;
  logic supply_sense_in_low = 1'b0;
  logic [1:0] kick_mode = 2'h0;
  logic kick_hi, kick_lo, kick_float;
  logic reset_out_n, reset_out_hi, supply_warn_n, irq;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rd;
  int errors = 0;
  int comparisons = 0;

  always #50 aclk = ~aclk;

  sws_supervisor #(.WDOG_TIMEOUT_CYC(WD), .RESET_HOLD_CYC(HD), .ADDR_W(8)) u_sws_supervisor (
    .aclk(aclk), .aresetn(aresetn), .main_supply_low(main_supply_low), .backup_mode_in(backup_mode_in),
    .watchdog_kick_in_hi(kick_hi), .watchdog_kick_in_lo(kick_lo), .watchdog_kick_in_float(kick_float),
    .supply_sense_in_low(supply_sense_in_low), .reset_out_n(reset_out_n), .reset_out_hi(reset_out_hi),
    .supply_warn_n(supply_warn_n), .irq(irq), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));

  sws_host_model #(.KICK_GAP(20)) u_sws_host_model (
    .aclk(aclk), .kick_mode(kick_mode), .kick_hi(kick_hi), .kick_lo(kick_lo), .kick_float(kick_float));

  task automatic final_report;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // A hung handshake counts as a mismatch and ends the run
  task automatic bail;
    errors++;
    final_report();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (n > 50) bail();
    end while (!bvalid);
    r = bresp;
    // Ready stays high, so back-to-back calls never assign it twice in one step
  endtask

  task automatic rdw(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
      if (n > 50) bail();
    end while (!rvalid);
    d = rdata;
    r = rresp;
    // Ready stays high, so back-to-back calls never assign it twice in one step
  endtask

  // Waits until the reset output shows v, bounded
  task automatic wait_rst(input logic v, input int lim);
    int n;
    n = 0;
    while (reset_out_n !== v) begin
      @(posedge aclk);
      n++;
      if (n > lim) bail();
    end
  endtask

  // Counts cycles with reset low over a quiet stretch
  task automatic quiet(input int n);
    int lows;
    lows = 0;
    repeat (n) begin
      @(posedge aclk);
      if (reset_out_n !== 1'b1) lows++;
    end
    chk(lows, 0);
  endtask

  task automatic sc_regs;
    rdw(8'h00, rd, rsp);
    chk(rd, 32'h1);
    rdw(8'h08, rd, rsp);
    chk(rd, 32'h0);
    rdw(8'h10, rd, rsp);
    chk(rsp, 2'h3);
    wr(8'h0C, 32'hFFFF_FFFF, rsp);
    chk(rsp, 2'h0);
  endtask

  task automatic sc_supply;
    main_supply_low <= 1'b1;
    cyc(4);
    chk(reset_out_n, 1'b0);
    chk(reset_out_hi, 1'b1);
    main_supply_low <= 1'b0;
    cyc(HD);
    chk(reset_out_n, 1'b0);
    wait_rst(1'b1, 20);
    chk(reset_out_hi, 1'b0);
  endtask

  task automatic sc_warn;
    supply_sense_in_low <= 1'b1;
    cyc(4);
    chk(supply_warn_n, 1'b0);
    chk(reset_out_n, 1'b1);
    supply_sense_in_low <= 1'b0;
    cyc(4);
    chk(supply_warn_n, 1'b1);
  endtask

  task automatic sc_backup;
    kick_mode <= 2'h1;
    main_supply_low <= 1'b1;
    backup_mode_in <= 1'b1;
    cyc(4);
    chk({reset_out_n, reset_out_hi, supply_warn_n}, 3'b010);
    cyc(2 * WD);
    chk({reset_out_n, reset_out_hi, supply_warn_n}, 3'b010);
    backup_mode_in <= 1'b0;
    main_supply_low <= 1'b0;
    kick_mode <= 2'h0;
    wait_rst(1'b1, HD + 10);
  endtask

  task automatic sc_wdog;
    int n;
    wr(8'h08, 32'h1, rsp);
    rdw(8'h04, rd, rsp);
    kick_mode <= 2'h1;
    wait_rst(1'b0, WD + 10);
    n = 0;
    while (reset_out_n !== 1'b1 && n < 100) begin
      @(posedge aclk);
      n++;
    end
    chk(n, HD);
    chk(irq, 1'b1);
    rdw(8'h04, rd, rsp);
    chk(rd & 32'h1, 32'h1);
    cyc(2);
    chk(irq, 1'b0);
    wait_rst(1'b0, WD + 10);
    wait_rst(1'b1, HD + 5);
  endtask

  task automatic sc_kick;
    kick_mode <= 2'h2;
    quiet(6 * WD);
    kick_mode <= 2'h0;
    quiet(6 * WD);
    kick_mode <= 2'h1;
    wr(8'h00, 32'h0, rsp);
    quiet(3 * WD);
    wr(8'h00, 32'h1, rsp);
    wait_rst(1'b0, WD + 10);
  endtask

  initial begin
    cyc(5);
    aresetn <= 1'b1;
    wait_rst(1'b1, HD + 10);
    sc_regs();
    sc_supply();
    sc_warn();
    sc_backup();
    sc_wdog();
    sc_kick();
    final_report();
  end
endmodule
